// ==== src/mdoc_ctrl.sv ====
// operating-state control of a message-based controller device
//
// Implementation choices: the placing of the registers and strobed register access.
`timescale 1ns/10ps
`default_nettype none
`include "mdoc_map.svh"
module mdoc_ctrl
   import mdoc_pkg::*;
(
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   // register port
   input wire logic [3:0] reg_addr_in,
   input wire logic [15:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [15:0] reg_rdata_out,
   // diagnostic_state result
   input wire logic diag_pass_in,
   // subordinate access port
   output logic sub_req_out,
   output logic sub_wr_out,
   output logic [1:0] sub_idx_out,
   output logic [7:0] sub_off_out,
   output logic [15:0] sub_wdata_out,
   input wire logic sub_ack_in,
   input wire logic [15:0] sub_rdata_in,
   input wire logic [3:0] sub_msg_in,
   // bus activity
   output logic bus_enable_out,
   output logic irq_drop_out,
   output logic ready_out
);
   mdoc_state_t state_reg, state_next;
   mdoc_step_t step_reg, step_next;
   logic ctrl_reset_reg;
   logic softreq_reg;
   logic root_reg;
   logic fail_reg;
   logic [3:0] sublist_reg;
   logic [3:0] master_reg;
   logic [15:0] irqmap_reg;
   logic [15:0] events_reg;
   logic [15:0] respen_reg;
   logic [15:0] reply_reg;
   logic [15:0] rdata_reg;
   logic [1:0] idx_reg;
   logic req_reg;
   logic wr_reg;
   logic [7:0] off_reg;
   logic [15:0] wdata_reg;
   logic refused_reg;
   logic drop_reg;
   logic diag_s1_reg, diag_s2_reg;
   logic timer_load;
   logic [15:0] timer_count;
   logic timer_done;

   ////////////////////////////////////////////////////////////////////////////////
   // decode
   wire wr_ctrl = reg_wr_in && (reg_addr_in == `MDOC_A_CTRL);
   wire wr_cmd = reg_wr_in && (reg_addr_in == `MDOC_A_CMD);
   wire wr_sub = reg_wr_in && (reg_addr_in == `MDOC_A_SUBLIST);
   wire wr_irq = reg_wr_in && (reg_addr_in == `MDOC_A_IRQMAP);
   wire wr_evt = reg_wr_in && (reg_addr_in == `MDOC_A_EVENTS);
   wire wr_rsp = reg_wr_in && (reg_addr_in == `MDOC_A_RESPEN);
   wire is_activate = wr_cmd && (reg_wdata_in[15:9] == 7'(`MDOC_CMD_ACTIVATE >> 9));
   wire in_setup = (state_reg == MDOC_SETUP);
   wire in_active = (state_reg == MDOC_ACTIVE);
   // hierarchy and irq line edits only in setup
   wire cfg_lock = !in_setup;
   wire cfg_refused = (wr_sub || wr_irq) && cfg_lock;
   // soft reset: bit written set, then cleared
   wire soft_go = wr_ctrl && softreq_reg && !reg_wdata_in[`MDOC_B_RESET];
   wire in_list = sublist_reg[idx_reg];
   wire last_sub = (idx_reg == 2'(`MDOC_NSUB - 1));
   wire [15:0] status_word = {10'h000, in_active, (state_reg == MDOC_DIAG), refused_reg,
                              fail_reg, root_reg, in_active};
   // message based subordinates get capability read and activate, and announce only when their master bit is set;
   // the others only get the configuration write
   wire sub_is_msg = sub_msg_in[idx_reg];
   wire want_req = in_list && (((step_reg == MDOC_SUB_CAP) && sub_is_msg)
                   || ((step_reg == MDOC_SUB_ANNOUNCE) && sub_is_msg && master_reg[idx_reg])
                   || ((step_reg == MDOC_SUB_ACT) && sub_is_msg)
                   || ((step_reg == MDOC_SUB_CFG) && !sub_is_msg));

   ////////////////////////////////////////////////////////////////////////////////
   // synchronise the diagnostic_state pin
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         diag_s1_reg <= 1'b0;
         diag_s2_reg <= 1'b0;
      end else begin
         diag_s1_reg <= diag_pass_in;
         diag_s2_reg <= diag_s1_reg;
      end
   end

   mdoc_timer u_timer (
      .core_clk_in(core_clk_in),
      .rst_n_in(rst_n_in),
      .load_in(timer_load),
      .count_in(timer_count),
      .done_out(timer_done)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // operating state and bring-up step selection
   always_comb begin
      state_next = state_reg;
      step_next = step_reg;
      timer_load = 1'b0;
      timer_count = `MDOC_DIAG_CYC;
      case (state_reg)
         MDOC_HARD: begin
            // hard reset always runs on into diagnostic_state
            state_next = MDOC_DIAG;
            timer_load = 1'b1;
         end
         MDOC_DIAG: begin
            if (timer_done && diag_s2_reg) begin
               state_next = MDOC_SETUP;
            end
         end
         MDOC_SETUP: begin
            if (is_activate) begin
               state_next = MDOC_BRINGUP;
               step_next = MDOC_SUB_CAP;
               timer_load = 1'b1;
               timer_count = `MDOC_WAIT_CYC;
            end
         end
         MDOC_BRINGUP: begin
            if (step_reg == MDOC_SUB_DONE) begin
               state_next = fail_reg ? MDOC_SETUP : MDOC_ACTIVE;
               step_next = MDOC_SUB_IDLE;
            end else if (req_reg && !sub_ack_in && timer_done) begin
               step_next = MDOC_SUB_DONE; // no answer counts as failure
            end else if (!req_reg || sub_ack_in) begin
               timer_load = 1'b1;
               timer_count = `MDOC_WAIT_CYC;
               // last index is done once acked, or when it needs no request at all
               if (last_sub && (req_reg || !want_req)) begin
                  case (step_reg)
                     MDOC_SUB_CAP: step_next = MDOC_SUB_ANNOUNCE;
                     MDOC_SUB_ANNOUNCE: step_next = MDOC_SUB_ACT;
                     MDOC_SUB_ACT: step_next = MDOC_SUB_CFG;
                     MDOC_SUB_CFG: step_next = MDOC_SUB_DONE;
                     default: step_next = MDOC_SUB_DONE;
                  endcase
               end
            end
         end
         MDOC_ACTIVE: begin
            state_next = MDOC_ACTIVE;
         end
         default: state_next = MDOC_HARD;
      endcase
      if (soft_go) begin
         state_next = MDOC_DIAG;
         step_next = MDOC_SUB_IDLE;
         timer_load = 1'b1;
         timer_count = `MDOC_DIAG_CYC;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // state registers
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_reg <= MDOC_HARD;
         step_reg <= MDOC_SUB_IDLE;
      end else begin
         state_reg <= state_next;
         step_reg <= step_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // subordinate sequencing: at most one request per listed subordinate and step
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         idx_reg <= 2'b00;
         req_reg <= 1'b0;
         wr_reg <= 1'b0;
         off_reg <= 8'h00;
         wdata_reg <= 16'h0000;
         master_reg <= 4'h0;
         fail_reg <= 1'b0;
      end else if (state_reg != MDOC_BRINGUP || step_next != step_reg || soft_go) begin
         idx_reg <= 2'b00;
         req_reg <= 1'b0;
         if (state_reg == MDOC_SETUP && is_activate) begin
            fail_reg <= 1'b0;
            master_reg <= 4'h0;
         end
         if (state_reg == MDOC_BRINGUP && req_reg && !sub_ack_in && timer_done) begin
            fail_reg <= 1'b1;
         end
         // the last index acks in the very cycle its step ends: keep its answer
         if (state_reg == MDOC_BRINGUP && req_reg && sub_ack_in && !soft_go) begin
            if (step_reg == MDOC_SUB_CAP) begin
               master_reg[idx_reg] <= sub_rdata_in[`MDOC_B_MASTER];
            end
            if (step_reg == MDOC_SUB_ACT && sub_msg_in[idx_reg]) begin
               fail_reg <= fail_reg | sub_rdata_in[`MDOC_B_ERR];
            end
         end
      end else if (req_reg) begin
         if (sub_ack_in) begin
            req_reg <= 1'b0;
            idx_reg <= idx_reg + 2'b01;
            if (step_reg == MDOC_SUB_CAP) begin
               master_reg[idx_reg] <= sub_rdata_in[`MDOC_B_MASTER];
            end
            if (step_reg == MDOC_SUB_ACT && sub_msg_in[idx_reg]) begin
               fail_reg <= fail_reg | sub_rdata_in[`MDOC_B_ERR];
            end
         end
      end else if (want_req) begin
         req_reg <= 1'b1;
         // only standard register offsets are ever used
         wr_reg <= (step_reg != MDOC_SUB_CAP);
         off_reg <= (step_reg == MDOC_SUB_CFG) ? `MDOC_STD_LIMIT - 8'h02 : 8'h08;
         wdata_reg <= (step_reg == MDOC_SUB_CFG) ? irqmap_reg
                    : (step_reg == MDOC_SUB_ANNOUNCE) ? 16'hBE00
                    : `MDOC_CMD_ACTIVATE;
      end else if (!last_sub) begin
         idx_reg <= idx_reg + 2'b01;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // configuration and reply registers
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sublist_reg <= `MDOC_RST_SUBLIST;
         irqmap_reg <= `MDOC_RST_IRQMAP;
         events_reg <= `MDOC_RST_EVENTS;
         respen_reg <= `MDOC_RST_RESPEN;
         reply_reg <= 16'h0000;
         root_reg <= 1'b0;
         refused_reg <= 1'b0;
         softreq_reg <= 1'b0;
         ctrl_reset_reg <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            softreq_reg <= reg_wdata_in[`MDOC_B_RESET];
            ctrl_reset_reg <= reg_wdata_in[`MDOC_B_RESET];
         end
         if (state_reg == MDOC_DIAG && state_next == MDOC_SETUP) begin
            sublist_reg <= `MDOC_RST_SUBLIST;
            irqmap_reg <= `MDOC_RST_IRQMAP;
            events_reg <= `MDOC_RST_EVENTS;
            respen_reg <= `MDOC_RST_RESPEN;
            root_reg <= 1'b0;
         end else begin
            if (wr_sub && !cfg_lock) sublist_reg <= reg_wdata_in[3:0];
            if (wr_irq && !cfg_lock) irqmap_reg <= reg_wdata_in;
            if (wr_evt) events_reg <= reg_wdata_in;
            if (wr_rsp) respen_reg <= reg_wdata_in;
         end
         if (cfg_refused) refused_reg <= 1'b1;
         else if (wr_ctrl && reg_wdata_in[`MDOC_B_FAIL]) refused_reg <= 1'b0;
         if (in_setup && is_activate) begin
            root_reg <= reg_wdata_in[`MDOC_CMD_ROOTBIT];
         end
         // reply at end of bring-up, or at once when already active
         if (state_reg == MDOC_BRINGUP && step_reg == MDOC_SUB_DONE) begin
            reply_reg <= fail_reg ? `MDOC_REPLY_FAIL : `MDOC_REPLY_OK;
         end else if (in_active && is_activate) begin
            reply_reg <= `MDOC_REPLY_OK;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // read data and outputs
   wire [15:0] rd_mux = (reg_addr_in == `MDOC_A_CTRL) ? {15'h0000, ctrl_reset_reg}
                      : (reg_addr_in == `MDOC_A_STATUS) ? status_word
                      : (reg_addr_in == `MDOC_A_REPLY) ? reply_reg
                      : (reg_addr_in == `MDOC_A_SUBLIST) ? {12'h000, sublist_reg}
                      : (reg_addr_in == `MDOC_A_IRQMAP) ? irqmap_reg
                      : (reg_addr_in == `MDOC_A_EVENTS) ? events_reg
                      : (reg_addr_in == `MDOC_A_RESPEN) ? respen_reg
                      : (reg_addr_in == `MDOC_A_ACCESS) ? {12'h000, master_reg}
                      : 16'h0000;

   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rdata_reg <= 16'h0000;
         drop_reg <= 1'b0;
         ready_out <= 1'b0;
         bus_enable_out <= 1'b0;
      end else begin
         rdata_reg <= reg_rd_in ? rd_mux : 16'h0000;
         drop_reg <= in_setup && is_activate;
         ready_out <= (state_next == MDOC_ACTIVE);
         bus_enable_out <= (state_next == MDOC_ACTIVE) || (state_next == MDOC_BRINGUP);
      end
   end

   assign reg_rdata_out = rdata_reg;
   assign irq_drop_out = drop_reg;
   assign sub_req_out = req_reg;
   assign sub_wr_out = wr_reg;
   assign sub_idx_out = idx_reg;
   assign sub_off_out = off_reg;
   assign sub_wdata_out = wdata_reg;
endmodule
`default_nettype wire

// ==== pkg/mdoc_map.svh ====
// register map, field positions, reset values and timing counts of the operation control block
// Contract
// - activate in setup enters bring-up, drops interrupts
// - read capabilities, announce controller to masters
// - forward activate, await every subordinate response
// - configure plain subordinates, allocate irq lines
// - success enters active, ready set; failure setup
// - reply low holds own and subordinate states
// - activate while active only returns state reply
// - ready reads zero in setup and bring-up
// - ready reads one in active
// - activate carries root-of-hierarchy flag
// - active refuses hierarchy and irq line changes
// - never control devices outside subordinate list
// - touch only standard registers of subordinates
// - system reset enters hard reset, then setup
// - reset bit set then cleared gives soft reset
// - soft reset deactivates only this device
// - hard reset terminates all operation at once
// - diagnostic_state pass loads default configuration
// - master capability bit marks bus master subordinates
`ifndef MDOC_MAP_SVH
`define MDOC_MAP_SVH
`define MDOC_ADDR_W 4
`define MDOC_A_CTRL 4'h0
`define MDOC_A_STATUS 4'h1
`define MDOC_A_CMD 4'h2
`define MDOC_A_REPLY 4'h3
`define MDOC_A_SUBLIST 4'h4
`define MDOC_A_IRQMAP 4'h5
`define MDOC_A_EVENTS 4'h6
`define MDOC_A_RESPEN 4'h7
`define MDOC_A_ACCESS 4'h8
`define MDOC_B_RESET 0
`define MDOC_B_FAIL 1
`define MDOC_B_READY 0
`define MDOC_B_ROOT 1
`define MDOC_B_ERR 2
`define MDOC_B_REFUSED 3
`define MDOC_B_DIAG 4
`define MDOC_B_ACTIVE 5
`define MDOC_B_MASTER 0
`define MDOC_CMD_ACTIVATE 16'hFC00
`define MDOC_CMD_ROOTBIT 8
`define MDOC_NSUB 4
`define MDOC_SUB_W 2
`define MDOC_DIAG_CYC 16'h0010
`define MDOC_WAIT_CYC 16'h0100
`define MDOC_RST_EVENTS 16'hFFFF
`define MDOC_RST_RESPEN 16'h0000
`define MDOC_RST_IRQMAP 16'h0000
`define MDOC_RST_SUBLIST 4'h0
`define MDOC_STD_LIMIT 8'h40
`define MDOC_REPLY_OK 16'hFFFE
`define MDOC_REPLY_FAIL 16'hFFF0
`endif

// ==== pkg/mdoc_pkg.sv ====
// types of the operation control block
package mdoc_pkg;
   typedef enum logic [2:0] {
      MDOC_HARD, MDOC_DIAG, MDOC_SETUP, MDOC_BRINGUP, MDOC_ACTIVE
   } mdoc_state_t;
   typedef enum logic [2:0] {
      MDOC_SUB_IDLE, MDOC_SUB_CAP, MDOC_SUB_ANNOUNCE, MDOC_SUB_ACT, MDOC_SUB_CFG, MDOC_SUB_DONE
   } mdoc_step_t;
endpackage

// ==== src/mdoc_timer.sv ====
// down counter used for diagnostic_state and subordinate response timeouts
`timescale 1ns/10ps
`default_nettype none
module mdoc_timer
   import mdoc_pkg::*;
(
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   input wire logic load_in,
   input wire logic [15:0] count_in,
   output logic done_out
);
   logic [15:0] cnt_reg;
   // load then count to zero
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cnt_reg <= 16'h0000;
      end else if (load_in) begin
         cnt_reg <= count_in;
      end else if (cnt_reg != 16'h0000) begin
         cnt_reg <= cnt_reg - 16'h0001;
      end
   end
   assign done_out = (cnt_reg == 16'h0000) && !load_in;
endmodule
`default_nettype wire

// ==== test/mdoc_ctrl_asserts.sv ====
// port assertions of the operation control block
`timescale 1ns/10ps
`default_nettype none
`include "mdoc_map.svh"
module mdoc_ctrl_asserts
   import mdoc_pkg::*;
(
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   input wire logic [3:0] reg_addr_in,
   input wire logic reg_rd_in,
   input wire logic [15:0] reg_rdata_out,
   input wire logic sub_req_out,
   input wire logic sub_ack_in,
   input wire logic [1:0] sub_idx_out,
   input wire logic [7:0] sub_off_out,
   input wire logic bus_enable_out,
   input wire logic irq_drop_out,
   input wire logic ready_out
);
   default clocking dc @(posedge core_clk_in); endclocking
   default disable iff (!rst_n_in);
   ////////////////////////////////////////////////////////////////////////////
   // steps of a subordinate access and of a status read
   sequence req_wait; sub_req_out && !sub_ack_in; endsequence
   sequence req_done; sub_req_out && sub_ack_in; endsequence
   sequence stat_rd; reg_rd_in && reg_addr_in == `MDOC_A_STATUS; endsequence
   ready_bus_a: assert property (ready_out |-> bus_enable_out)
      else $error("ready while bus disabled");
   req_hold_a: assert property (req_wait |=> sub_req_out && $stable(sub_idx_out)
      && $stable(sub_off_out)) else $error("request changed before ack");
   req_release_a: assert property (req_done |=> !sub_req_out)
      else $error("request held after ack");
   std_only_a: assert property (sub_req_out |-> sub_off_out < `MDOC_STD_LIMIT)
      else $error("device dependent offset touched");
   bringup_only_a: assert property (sub_req_out |-> bus_enable_out && !ready_out)
      else $error("subordinate access outside bring-up");
   req_bound_a: assert property ($rose(sub_req_out) |-> ##[1:400] !sub_req_out)
      else $error("request never ended");
   irq_pulse_a: assert property (irq_drop_out |=> !irq_drop_out)
      else $error("interrupt drop longer than a pulse");
   ready_read_a: assert property (stat_rd |=>
      reg_rdata_out[`MDOC_B_READY] == $past(ready_out)) else $error("status ready bit differs");
   reset_clear_a: assert property ($rose(rst_n_in) |-> !ready_out && !bus_enable_out)
      else $error("active right after reset");
endmodule
bind mdoc_ctrl mdoc_ctrl_asserts u_chk (.core_clk_in, .rst_n_in, .reg_addr_in, .reg_rd_in,
   .reg_rdata_out, .sub_req_out, .sub_ack_in, .sub_idx_out, .sub_off_out, .bus_enable_out,
   .irq_drop_out, .ready_out);
`default_nettype wire

// ==== test/mdoc_sub_model.sv ====
// subordinate model answering the controller's access port
`timescale 1ns/10ps
`default_nettype none
`include "mdoc_map.svh"
module mdoc_sub_model
   import mdoc_pkg::*;
(
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   input wire logic req_in,
   input wire logic wr_in,
   input wire logic [1:0] idx_in,
   input wire logic [7:0] off_in,
   input wire logic [15:0] wdata_in,
   input wire logic [3:0] list_in,
   input wire logic err_in,
   output logic ack_out,
   output logic [15:0] rdata_out
);
   logic [3:0] wait_reg;
   int bad_cnt, ann_cnt, act_cnt, cfg_cnt;
   ////////////////////////////////////////////////////////////////////////////
   // latency grows with the index; idle data toggles so stale values never match
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ack_out <= 1'b0;
         wait_reg <= 4'h0;
         rdata_out <= 16'h5A5A;
      end else if (req_in && !ack_out && wait_reg < {idx_in, 2'b00}) begin
         wait_reg <= wait_reg + 4'h1;
         rdata_out <= ~rdata_out;
      end else if (req_in && !ack_out) begin
         ack_out <= 1'b1;
         wait_reg <= 4'h0;
         rdata_out <= {13'h0000, err_in, 1'b0, idx_in == 2'b00}; // only index 0 masters
         bad_cnt <= bad_cnt + int'(!list_in[idx_in] || off_in >= `MDOC_STD_LIMIT);
         ann_cnt <= ann_cnt + int'(wr_in && wdata_in == 16'hBE00);
         act_cnt <= act_cnt + int'(wr_in && wdata_in[15:9] == 7'h7E);
         cfg_cnt <= cfg_cnt + int'(wr_in && off_in == 8'h3E);
      end else begin
         ack_out <= 1'b0;
         rdata_out <= ~rdata_out;
      end
   end
endmodule
`default_nettype wire

// ==== test/mdoc_ctrl_tb_top.sv ====
// testbench of the operation control block
`timescale 1ns/10ps
`default_nettype none
`include "mdoc_map.svh"
module mdoc_ctrl_tb_top
   import mdoc_pkg::*;
;
   logic clk, rst_n, rd, wr, diag_pass, err, req, swr, ack, bus_en, drop, rdy;
   logic [3:0] addr, msg, lst;
   logic [15:0] wdata, rdata, d, swdata, srdata;
   logic [1:0] idx;
   logic [7:0] off;
   int fail_count, checks, drops;
   mdoc_ctrl dut (.core_clk_in(clk), .rst_n_in(rst_n), .reg_addr_in(addr), .reg_wdata_in(wdata),
      .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .diag_pass_in(diag_pass),
      .sub_req_out(req), .sub_wr_out(swr), .sub_idx_out(idx), .sub_off_out(off),
      .sub_wdata_out(swdata), .sub_ack_in(ack), .sub_rdata_in(srdata), .sub_msg_in(msg),
      .bus_enable_out(bus_en), .irq_drop_out(drop), .ready_out(rdy));
   mdoc_sub_model u_sub (.core_clk_in(clk), .rst_n_in(rst_n), .req_in(req), .wr_in(swr),
      .idx_in(idx), .off_in(off), .wdata_in(swdata), .list_in(lst), .err_in(err),
      .ack_out(ack), .rdata_out(srdata));
   ////////////////////////////////////////////////////////////////////////////
   // bus cycles, comparison and closing
   task wr_reg(input logic [3:0] a, input logic [15:0] v);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= v;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task rd_reg(input logic [3:0] a, output logic [15:0] v);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 v = rdata;
   endtask
   task chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task rd_chk(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e);
      rd_reg(a, d);
      chk(d & m, e);
   endtask
   task wait_st(input logic [15:0] m, input logic [15:0] e);
      for (int i = 0; i < 3000; i++) begin
         rd_reg(`MDOC_A_STATUS, d);
         if ((d & m) === e) break;
      end
      chk(d & m, e);
   endtask
   task wrap_up;
      $display("checks=%0d fail_count=%0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // clock, drop pulse count and watchdog
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   always @(posedge clk) if (drop === 1'b1) drops++;
   initial begin
      #400000;
      fail_count++;
      wrap_up();
   end
   ////////////////////////////////////////////////////////////////////////////
   // scenarios
   initial begin
      {rst_n, rd, wr, err, addr, wdata} = '0;
      diag_pass = 1'b1;
      msg = 4'h3;
      lst = 4'hF;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      wait_st(16'h0010, 16'h0000);
      rd_chk(`MDOC_A_STATUS, 16'h0021, 16'h0000);
      rd_chk(`MDOC_A_EVENTS, 16'hFFFF, `MDOC_RST_EVENTS);
      rd_chk(`MDOC_A_RESPEN, 16'hFFFF, `MDOC_RST_RESPEN);
      rd_chk(`MDOC_A_IRQMAP, 16'hFFFF, `MDOC_RST_IRQMAP);
      rd_chk(`MDOC_A_SUBLIST, 16'h000F, 16'h0000);
      wr_reg(`MDOC_A_SUBLIST, 16'h000F);
      wr_reg(`MDOC_A_IRQMAP, 16'h00A5);
      wr_reg(`MDOC_A_CMD, `MDOC_CMD_ACTIVATE | 16'h0100);
      wait_st(16'h0001, 16'h0001);
      rd_chk(`MDOC_A_STATUS, 16'h0023, 16'h0023);
      chk({15'h0000, rdy}, 16'h0001);
      rd_chk(`MDOC_A_REPLY, 16'hFFFF, `MDOC_REPLY_OK);
      rd_chk(`MDOC_A_ACCESS, 16'h000F, 16'h0001);
      chk(16'(u_sub.ann_cnt), 16'h0001);
      chk(16'(u_sub.act_cnt), 16'h0002);
      chk(16'(u_sub.cfg_cnt), 16'h0002);
      chk(16'(u_sub.bad_cnt), 16'h0000);
      chk(16'(drops), 16'h0001);
      wr_reg(`MDOC_A_CMD, `MDOC_CMD_ACTIVATE);
      rd_chk(`MDOC_A_REPLY, 16'hFFFF, `MDOC_REPLY_OK);
      chk(16'(u_sub.act_cnt), 16'h0002);
      wr_reg(`MDOC_A_SUBLIST, 16'h0003);
      wr_reg(`MDOC_A_IRQMAP, 16'h0000);
      rd_chk(`MDOC_A_SUBLIST, 16'h000F, 16'h000F);
      rd_chk(`MDOC_A_IRQMAP, 16'hFFFF, 16'h00A5);
      rd_chk(`MDOC_A_STATUS, 16'h0008, 16'h0008);
      wr_reg(`MDOC_A_CTRL, 16'h0002);
      rd_chk(`MDOC_A_STATUS, 16'h0008, 16'h0000);
      wr_reg(`MDOC_A_CTRL, 16'h0001);
      wr_reg(`MDOC_A_CTRL, 16'h0000);
      rd_chk(`MDOC_A_STATUS, 16'h0031, 16'h0010);
      chk({15'h0000, bus_en}, 16'h0000);
      wait_st(16'h0010, 16'h0000);
      rd_chk(`MDOC_A_SUBLIST, 16'h000F, 16'h0000);
      wr_reg(`MDOC_A_SUBLIST, 16'h000F);
      wr_reg(`MDOC_A_CMD, `MDOC_CMD_ACTIVATE);
      repeat (3) @(posedge clk);
      rst_n <= 1'b0;
      #1 chk({14'h0000, bus_en, rdy}, 16'h0000);
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      wait_st(16'h0010, 16'h0000);
      rd_chk(`MDOC_A_SUBLIST, 16'h000F, 16'h0000);
      lst <= 4'h3;
      err <= 1'b1;
      wr_reg(`MDOC_A_SUBLIST, 16'h0003);
      wr_reg(`MDOC_A_CMD, `MDOC_CMD_ACTIVATE);
      wait_st(16'h0004, 16'h0004);
      repeat (40) @(posedge clk);
      chk({15'h0000, bus_en}, 16'h0000);
      rd_chk(`MDOC_A_STATUS, 16'h0021, 16'h0000);
      rd_chk(`MDOC_A_REPLY, 16'hFFFF, `MDOC_REPLY_FAIL);
      chk(16'(u_sub.bad_cnt), 16'h0000);
      wrap_up();
   end
endmodule
`default_nettype wire
